/* File: verilog/charge_cfg.svh */
`ifndef CHARGE_CFG_SVH
`define CHARGE_CFG_SVH

// apb register byte addresses
`define REG_CTRL_A 12'h000
`define REG_CTRL_B 12'h004
`define REG_CTRL_C 12'h008
`define REG_CTRL_D 12'h00c
`define REG_CTRL_E 12'h010
`define REG_STATUS 12'h014

// charge_control_a fields
`define CA_DEAD_EN 0
`define CA_TOTAL_EN 1
`define CA_TOPOFF_TIMER_EN 2
`define CA_HALT 3
`define CA_CHG_EN 4
`define CA_FAULT_CLR 5
`define CA_RESET 32'h0000_0013

// charge_control_b fields: total timer length in hours [2:0], weak level [15:8]
`define CB_RESET 32'h0000_8005
`define CC_RESET 32'h0000_002d
`define CD_RESET 32'h0000_0010
`define CE_RESET 32'h0000_00d2

// battery code scale: 20 mV per lsb
`define MV_PER_LSB 20
`define PREQUAL_MV 2500
`define RECHARGE_DROP_MV 150

// currents in ma, current code in 10 ma units
`define TRICKLE_MA 90
`define FAST_DEFAULT_MA 450
`define STEP_MA 10

// times
`define CLK_MHZ 125
`define DEAD_MIN 30
`define TOPOFF_MIN 30
`define DEBOUNCE_MS 60
`define SOFT_STEP_US 10
`define MS_CYCLES (`CLK_MHZ * 1000)
`define MIN_CYCLES_DEF (64'(`MS_CYCLES) * 64'hea60)
`define DEBOUNCE_CYCLES (`MS_CYCLES * `DEBOUNCE_MS)
`define SOFT_CYCLES (`CLK_MHZ * `SOFT_STEP_US)

`endif

/* File: verilog/charge_pkg.sv */
`default_nettype none
package charge_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_PREQUAL, ST_FAST, ST_CV, ST_TOPOFF, ST_DONE, ST_FAULT
   } charge_state_t;

   typedef enum logic [2:0] {
      SRC_NONE, SRC_SDP, SRC_DCP, SRC_CDP, SRC_CARKIT, SRC_TRAVEL
   } source_kind_t;

   typedef struct packed {
      logic supplyValid;
      source_kind_t sourceKind;
      logic [7:0] battCode;
      logic [7:0] chargeCurrent;
   } sense_t;

   typedef struct packed {
      logic deadTimeout;
      logic totalTimeout;
   } fault_flags_t;
endpackage
`default_nettype wire

/* File: verilog/charge_sequencer.sv */
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "charge_cfg.svh"

module charge_sequencer #(
   parameter longint unsigned MIN_CYCLES = `MIN_CYCLES_DEF
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog sense
   input wire charge_pkg::sense_t sense,
   // charger drive
   output logic chargeOn,
   output logic [7:0] currentCode,
   output logic cvMode,
   output logic [7:0] regulationCode
);
   logic rstSync1_reg;
   logic rstSync2_reg;
   wire logic rstN = rstSync2_reg;


   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstSync1_reg <= 1'b0;
         rstSync2_reg <= 1'b0;
      end else begin
         rstSync1_reg <= 1'b1;
         rstSync2_reg <= rstSync1_reg;
      end
   end

   function automatic logic [7:0] mvToCode(input int unsigned mv);
      mvToCode = 8'((mv + `MV_PER_LSB - 1) / `MV_PER_LSB);
   endfunction

   // status: state in [2:0], faults {dead, total} in [4:3], current code in [13:6]
   function automatic logic [31:0] statusWord(
         input charge_pkg::charge_state_t st,
         input charge_pkg::fault_flags_t fl,
         input logic [7:0] code);
      logic [31:0] word;
      word = 32'h0000_0000;
      word[2:0] = st;
      word[4:3] = fl;
      word[13:6] = code;
      statusWord = word;
   endfunction

   localparam logic [7:0] PREQUAL_CODE = mvToCode(`PREQUAL_MV);
   localparam logic [7:0] DROP_CODE = mvToCode(`RECHARGE_DROP_MV);
   localparam logic [7:0] TRICKLE_CODE = 8'(`TRICKLE_MA / `STEP_MA);


   // registers
   logic [31:0] ctrlA_reg;
   logic [31:0] ctrlB_reg;
   logic [31:0] ctrlC_reg;
   logic [31:0] ctrlD_reg;
   logic [31:0] ctrlE_reg;
   charge_pkg::fault_flags_t faults_reg;
   charge_pkg::charge_state_t state_reg;

   wire logic deadBattTimerEn = ctrlA_reg[`CA_DEAD_EN];
   wire logic totalTimerEn = ctrlA_reg[`CA_TOTAL_EN];
   wire logic topoffTimerEn = ctrlA_reg[`CA_TOPOFF_TIMER_EN];
   wire logic haltAfterFull = ctrlA_reg[`CA_HALT];
   wire logic chargerEnable = ctrlA_reg[`CA_CHG_EN];
   wire logic [2:0] totalTimerLen = ctrlB_reg[2:0];
   wire logic [7:0] weakBattLevel = ctrlB_reg[15:8];
   wire logic [7:0] fastCurrentSel = ctrlC_reg[7:0];
   wire logic [7:0] endCurrentSel = ctrlD_reg[7:0];
   wire logic [7:0] regulationVoltageSel = ctrlE_reg[7:0];


   // apb: zero wait states, unmapped addresses answer with an error
   wire logic apbAccess = psel && penable;
   wire logic apbWrite = apbAccess && pwrite;
   logic mapped;
   assign pready = 1'b1;
   assign pslverr = apbAccess && !mapped;


   always_comb begin
      mapped = 1'b1;
      prdata = 32'h0000_0000;
      unique case (paddr)
         `REG_CTRL_A: prdata = ctrlA_reg;
         `REG_CTRL_B: prdata = ctrlB_reg;
         `REG_CTRL_C: prdata = ctrlC_reg;
         `REG_CTRL_D: prdata = ctrlD_reg;
         `REG_CTRL_E: prdata = ctrlE_reg;
         `REG_STATUS: prdata = statusWord(state_reg, faults_reg, currentCode);
         default: mapped = 1'b0;
      endcase
   end

   // fault clear is self-clearing, so ctrl a bit 5 always reads zero
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         ctrlA_reg <= `CA_RESET;
         ctrlB_reg <= `CB_RESET;
         ctrlC_reg <= `CC_RESET;
         ctrlD_reg <= `CD_RESET;
         ctrlE_reg <= `CE_RESET;
      end else if (apbWrite) begin
         // a write elsewhere must not leave the clear strobe standing
         ctrlA_reg[`CA_FAULT_CLR] <= 1'b0;
         unique case (paddr)
            `REG_CTRL_A: ctrlA_reg <= {26'h0, pwdata[5:0]};
            `REG_CTRL_B: ctrlB_reg <= {16'h0, pwdata[15:8], 5'h0, pwdata[2:0]};
            `REG_CTRL_C: ctrlC_reg <= {24'h0, pwdata[7:0]};
            `REG_CTRL_D: ctrlD_reg <= {24'h0, pwdata[7:0]};
            `REG_CTRL_E: ctrlE_reg <= {24'h0, pwdata[7:0]};
            default: ;
         endcase
      end else begin
         ctrlA_reg[`CA_FAULT_CLR] <= 1'b0;
      end
   end

   wire logic faultClear = ctrlA_reg[`CA_FAULT_CLR];


   // supply edge
   logic supplyPrev_reg;
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         supplyPrev_reg <= 1'b0;
      end else begin
         supplyPrev_reg <= sense.supplyValid;
      end
   end
   wire logic supplyRise = sense.supplyValid && !supplyPrev_reg;


   // minute tick; a minute at full clock rate needs 33 bits of divider
   logic [32:0] minDiv_reg;
   wire logic minTick = (minDiv_reg == MIN_CYCLES - 1);
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         minDiv_reg <= 33'h0;
      end else if (!sense.supplyValid || minTick) begin
         minDiv_reg <= 33'h0;
      end else begin
         minDiv_reg <= minDiv_reg + 33'h1;
      end
   end

   wire logic charging = (state_reg == charge_pkg::ST_PREQUAL) || (state_reg == charge_pkg::ST_FAST)
      || (state_reg == charge_pkg::ST_CV);
   wire logic [7:0] battCode = sense.battCode;


   // dead-battery timer, cleared on supply loss and restarted on each attach
   logic [5:0] deadMin_reg;
   logic deadRun_reg;
   wire logic deadExpire = deadRun_reg && deadBattTimerEn && minTick
      && (deadMin_reg == 6'(`DEAD_MIN - 1)) && (battCode <= weakBattLevel);
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         deadMin_reg <= 6'h0;
         deadRun_reg <= 1'b0;
      end else if (!sense.supplyValid) begin
         deadMin_reg <= 6'h0;
         deadRun_reg <= 1'b0;
      end else if (supplyRise) begin
         deadMin_reg <= 6'h0;
         deadRun_reg <= deadBattTimerEn;
      end else if (battCode > weakBattLevel || !deadBattTimerEn) begin
         deadRun_reg <= 1'b0;
      end else if (deadRun_reg && minTick) begin
         deadMin_reg <= deadMin_reg + 6'h1;
      end
   end

   // total-charge timer counts prequal, fast and cv only, never top-off
   logic [9:0] totalMin_reg;
   wire logic [9:0] totalLimit = 10'(totalTimerLen) * 10'd60;
   wire logic totalExpire = totalTimerEn && (totalMin_reg >= totalLimit) && charging;
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         totalMin_reg <= 10'h0;
      end else if (!sense.supplyValid || supplyRise || state_reg == charge_pkg::ST_IDLE) begin
         totalMin_reg <= 10'h0;
      end else if (charging && minTick && totalMin_reg != 10'h3ff) begin
         totalMin_reg <= totalMin_reg + 10'h1;
      end
   end

   // top-off timer
   logic [5:0] topMin_reg;
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         topMin_reg <= 6'h0;
      end else if (state_reg != charge_pkg::ST_TOPOFF) begin
         topMin_reg <= 6'h0;
      end else if (minTick) begin
         topMin_reg <= topMin_reg + 6'h1;
      end
   end
   wire logic topoffDone = minTick && (topMin_reg == 6'(`TOPOFF_MIN - 1));

   // debounce length is fixed in cycles, far beyond what a short run can reach

   // recharge debounce
   logic [23:0] debounce_reg;
   wire logic dropped = (32'(battCode) + 32'(DROP_CODE)) <= 32'(regulationVoltageSel);
   wire logic rechargeGo = (debounce_reg == 24'(`DEBOUNCE_CYCLES - 1));
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         debounce_reg <= 24'h0;
      end else if (state_reg != charge_pkg::ST_DONE || !dropped || rechargeGo) begin
         debounce_reg <= 24'h0;
      end else begin
         debounce_reg <= debounce_reg + 24'h1;
      end
   end

   // sticky faults; a new expiry wins over a clear
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         faults_reg <= '0;
      end else begin
         faults_reg.deadTimeout <= deadExpire
            || (faults_reg.deadTimeout && !faultClear && !supplyRise);
         faults_reg.totalTimeout <= totalExpire
            || (faults_reg.totalTimeout && !faultClear);
      end
   end

   wire logic atRegulation = battCode >= regulationVoltageSel;
   wire logic belowEnd = sense.chargeCurrent < endCurrentSel;


   // main sequencer; runs without host action
   charge_pkg::charge_state_t stateNext;
   always_comb begin
      stateNext = state_reg;
      unique case (state_reg)
         charge_pkg::ST_IDLE:
            if (chargerEnable && !faults_reg.totalTimeout) begin
               stateNext = charge_pkg::ST_PREQUAL;
            end
         charge_pkg::ST_PREQUAL:
            if (battCode >= PREQUAL_CODE) begin
               stateNext = charge_pkg::ST_FAST;
            end
         charge_pkg::ST_FAST:
            if (atRegulation) begin
               stateNext = charge_pkg::ST_CV;
            end
         charge_pkg::ST_CV:
            if (belowEnd && haltAfterFull) begin
               stateNext = topoffTimerEn ? charge_pkg::ST_TOPOFF : charge_pkg::ST_DONE;
            end
         charge_pkg::ST_TOPOFF:
            if (topoffDone) begin
               stateNext = charge_pkg::ST_DONE;
            end
         charge_pkg::ST_DONE:
            if (rechargeGo) begin
               stateNext = charge_pkg::ST_FAST;
            end
         charge_pkg::ST_FAULT:
            if (!chargerEnable) begin
               stateNext = charge_pkg::ST_IDLE;
            end
         default: stateNext = charge_pkg::ST_IDLE;
      endcase
      if (deadExpire || totalExpire) begin
         stateNext = charge_pkg::ST_FAULT;
      end
      if (!sense.supplyValid) begin
         stateNext = charge_pkg::ST_IDLE;
      end else if (state_reg != charge_pkg::ST_FAULT && !chargerEnable) begin
         stateNext = charge_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         state_reg <= charge_pkg::ST_IDLE;
      end else begin
         state_reg <= stateNext;
      end
   end

   // current target by source kind
   logic [7:0] fastTarget;
   always_comb begin
      unique case (sense.sourceKind)
         charge_pkg::SRC_DCP, charge_pkg::SRC_CDP, charge_pkg::SRC_CARKIT,
         charge_pkg::SRC_TRAVEL: fastTarget = fastCurrentSel;
         default: fastTarget = TRICKLE_CODE;
      endcase
   end

   // soft start: one step per interval, ramps up from trickle (from zero on a recharge out of done), drops at once
   logic [11:0] softDiv_reg;
   wire logic softTick = (softDiv_reg == 12'(`SOFT_CYCLES - 1));
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         softDiv_reg <= 12'h0;
      end else if (softTick) begin
         softDiv_reg <= 12'h0;
      end else begin
         softDiv_reg <= softDiv_reg + 12'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         currentCode <= 8'h0;
      end else if (state_reg == charge_pkg::ST_PREQUAL) begin
         currentCode <= TRICKLE_CODE;
      end else if (state_reg == charge_pkg::ST_FAST || state_reg == charge_pkg::ST_CV
         || state_reg == charge_pkg::ST_TOPOFF) begin
         if (currentCode > fastTarget) begin
            currentCode <= fastTarget;
         end else if (softTick && currentCode < fastTarget) begin
            currentCode <= currentCode + 8'h1;
         end
      end else begin
         currentCode <= 8'h0;
      end
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         chargeOn <= 1'b0;
         cvMode <= 1'b0;
         regulationCode <= 8'h0;
      end else begin
         chargeOn <= charging || state_reg == charge_pkg::ST_TOPOFF;
         cvMode <= state_reg == charge_pkg::ST_CV || state_reg == charge_pkg::ST_TOPOFF;
         regulationCode <= regulationVoltageSel;
      end
   end
endmodule

`default_nettype wire

/* File: sim/charge_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module charge_monitor #(
   parameter int unsigned MIN_CYCLES = 100
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // sense and drive
   input wire charge_pkg::sense_t sense,
   input wire logic chargeOn,
   input wire logic [7:0] currentCode,
   input wire logic cvMode,
   input wire logic [7:0] regulationCode
);
   localparam int DeadLim = 30 * MIN_CYCLES + 8;
   int lowCnt;
   // assumes the dead timer enable and weak level stay at reset values
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         lowCnt <= 0;
      end else if (!sense.supplyValid || !chargeOn) begin
         lowCnt <= 0;
      end else if (sense.battCode < 8'h80) begin
         lowCnt <= lowCnt + 1;
      end
   end
   default clocking mon_cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   property p_trickle;
      chargeOn && !cvMode && sense.battCode < 8'h7d && $past(sense.battCode) < 8'h7d
         |-> currentCode == 8'h09;
   endproperty
   a_trickle: assert property (p_trickle) else $error("trickle current wrong");
   property p_sdp;
      chargeOn && !cvMode && sense.sourceKind == charge_pkg::SRC_SDP
         && $past(sense.sourceKind, 2) == charge_pkg::SRC_SDP |-> currentCode <= 8'h09;
   endproperty
   a_sdp: assert property (p_sdp) else $error("standard port current too high");
   property p_soft;
      chargeOn && $past(chargeOn) && !cvMode && currentCode > $past(currentCode)
         |-> currentCode == $past(currentCode) + 8'h01;
   endproperty
   a_soft: assert property (p_soft) else $error("current jumped");
   property p_loss;
      !sense.supplyValid [*3] |-> !chargeOn;
   endproperty
   a_loss: assert property (p_loss) else $error("charging without supply");
   property p_dead;
      lowCnt < DeadLim;
   endproperty
   a_dead: assert property (p_dead) else $error("dead timer overran");
   property p_cv;
      $rose(cvMode) |-> chargeOn && sense.battCode >= regulationCode;
   endproperty
   a_cv: assert property (p_cv) else $error("early voltage mode");
   property p_regcopy;
      psel && penable && pwrite && paddr == 12'h010
         |-> ##2 regulationCode == $past(pwdata[7:0], 2);
   endproperty
   a_regcopy: assert property (p_regcopy) else $error("regulation code stale");
   property p_unmapped;
      psel && penable && paddr > 12'h014 |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
endmodule
bind charge_sequencer charge_monitor #(.MIN_CYCLES(MIN_CYCLES)) charge_monitor_inst (
   .core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .sense, .chargeOn, .currentCode, .cvMode, .regulationCode);
`default_nettype wire

/* File: sim/batt_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module batt_src_model (
   // bench controls
   input wire logic supplyOn,
   input wire charge_pkg::source_kind_t kind,
   input wire logic [7:0] battLevel,
   input wire logic [7:0] taperCode,
   // charger drive
   input wire logic chargeOn,
   input wire logic [7:0] currentCode,
   input wire logic cvMode,
   // sensed values
   output var charge_pkg::sense_t sense
);
   always_comb begin
      sense.supplyValid = supplyOn;
      // a detached source reports no port type
      sense.sourceKind = supplyOn ? kind : charge_pkg::SRC_NONE;
      sense.battCode = battLevel;
      // in voltage mode the cell sets the current, so it tapers on its own
      sense.chargeCurrent = !chargeOn ? 8'h00 : (cvMode ? taperCode : currentCode);
   end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "charge_cfg.svh"
module tb_top;
   localparam int unsigned MinCyc = 100;
   localparam int DeadCyc = 30 * MinCyc;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   charge_pkg::sense_t sense;
   logic supplyOn = 1'b0;
   charge_pkg::source_kind_t kind = charge_pkg::SRC_NONE;
   logic [7:0] battLevel = 8'h00;
   logic [7:0] taperCode = 8'h20;
   logic chargeOn;
   logic [7:0] currentCode;
   logic cvMode;
   logic [7:0] regulationCode;
   int nMismatch = 0;
   int checkCount = 0;
   int cycles = 0;
   charge_sequencer #(.MIN_CYCLES(MinCyc)) charge_sequencer_inst (
      .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sense(sense), .chargeOn(chargeOn), .currentCode(currentCode),
      .cvMode(cvMode), .regulationCode(regulationCode));
   batt_src_model batt_src_model_inst (
      .supplyOn(supplyOn), .kind(kind), .battLevel(battLevel), .taperCode(taperCode),
      .chargeOn(chargeOn), .currentCode(currentCode), .cvMode(cvMode), .sense(sense));
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   task automatic closeOut();
      if (nMismatch == 0 && checkCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checkCount++;
      if (got !== exp) begin
         nMismatch++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp, input string what);
      checkCount++;
      if (got !== exp) begin
         nMismatch++;
         $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // one idle edge first, so psel is never assigned twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      int k;
      k = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1 && k < 16) begin
         @(posedge core_clk);
         k++;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
      chkb(e, 1'b0, "write error");
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q & m, exp, "read");
   endtask
   task automatic plug(input logic on, input charge_pkg::source_kind_t k, input logic [7:0] b);
      supplyOn <= on;
      kind <= k;
      battLevel <= b;
      cyc(5);
   endtask
   task automatic tRegs();
      logic [31:0] q;
      logic e;
      rd(`REG_CTRL_A, 32'h3, 32'h3);
      rd(`REG_CTRL_B, 32'h5, 32'h7);
      chkb(pready, 1'b1, "ready idle");
      wr(`REG_CTRL_E, 32'hc8);
      rd(`REG_CTRL_E, 32'hc8, 32'hff);
      chk(32'(regulationCode), 32'hc8, "regulation copy");
      wr(`REG_CTRL_E, 32'hd2);
      apb(1'b0, 12'h018, 32'h0, q, e);
      chkb(e, 1'b1, "unmapped error");
      chk(q, 32'h0, "unmapped data");
   endtask
   task automatic tDead();
      plug(1'b1, charge_pkg::SRC_SDP, 8'h32);
      cyc(DeadCyc - 25);
      chkb(chargeOn, 1'b1, "short before limit");
      chk(32'(currentCode), 32'h9, "trickle");
      cyc(40);
      chkb(chargeOn, 1'b0, "short after limit");
      rd(`REG_STATUS, 32'h10, 32'h10);
      plug(1'b0, charge_pkg::SRC_NONE, 8'h32);
      plug(1'b1, charge_pkg::SRC_SDP, 8'h32);
      cyc(DeadCyc - 25);
      chkb(chargeOn, 1'b1, "fresh period");
      cyc(40);
      chkb(chargeOn, 1'b0, "second limit");
      plug(1'b0, charge_pkg::SRC_NONE, 8'h32);
   endtask
   task automatic tKinds();
      charge_pkg::source_kind_t ks [5] = '{charge_pkg::SRC_SDP, charge_pkg::SRC_DCP,
         charge_pkg::SRC_CDP, charge_pkg::SRC_CARKIT, charge_pkg::SRC_TRAVEL};
      for (int i = 0; i < 5; i++) begin
         plug(1'b1, ks[i], 8'h96);
         chkb(currentCode <= 8'h0a, 1'b1, "no jump");
         cyc(1400);
         chkb(chargeOn, 1'b1, "fast on");
         chkb(currentCode > 8'h09, ks[i] != charge_pkg::SRC_SDP, "port current");
         plug(1'b0, charge_pkg::SRC_NONE, 8'h96);
      end
   endtask
   task automatic tCv();
      plug(1'b1, charge_pkg::SRC_DCP, 8'hd2);
      chkb(cvMode, 1'b1, "voltage mode");
      taperCode <= 8'h08;
      cyc(200);
      chkb(cvMode, 1'b1, "hold without halt");
      wr(`REG_CTRL_A, 32'h1f);
      cyc(DeadCyc - 120);
      chkb(cvMode, 1'b1, "top-off running");
      cyc(140);
      chkb(chargeOn, 1'b0, "top-off over");
      // a glitch far shorter than the debounce must not restart charging
      battLevel <= 8'hc0;
      cyc(500);
      chkb(chargeOn, 1'b0, "glitch ignored");
      plug(1'b0, charge_pkg::SRC_NONE, 8'hd2);
      taperCode <= 8'h20;
      wr(`REG_CTRL_A, 32'h1b);
      plug(1'b1, charge_pkg::SRC_DCP, 8'hd2);
      taperCode <= 8'h08;
      cyc(20);
      chkb(chargeOn, 1'b0, "stop at end current");
      plug(1'b0, charge_pkg::SRC_NONE, 8'hd2);
      taperCode <= 8'h20;
      wr(`REG_CTRL_A, 32'h13);
   endtask
   task automatic tTotal();
      wr(`REG_CTRL_B, 32'h8001);
      plug(1'b1, charge_pkg::SRC_SDP, 8'h96);
      cyc(60 * MinCyc - 30);
      chkb(chargeOn, 1'b1, "before total limit");
      cyc(60);
      chkb(chargeOn, 1'b0, "total limit");
      rd(`REG_STATUS, 32'h08, 32'h08);
      wr(`REG_CTRL_A, 32'h03);
      wr(`REG_CTRL_A, 32'h33);
      cyc(20);
      chkb(chargeOn, 1'b1, "restart after re-enable");
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         nMismatch++;
         closeOut();
      end
   end
   initial begin
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      cyc(4);
      tRegs();
      tDead();
      tKinds();
      tCv();
      tTotal();
      closeOut();
   end
endmodule
`default_nettype wire
